//--- hw/ppr_byte_packer.sv
// Pixel to byte serializer for 8-bit, 16-bit and packed 12-bit output
`timescale 1ns/1ps
`default_nettype none
module ppr_byte_packer
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Format, stable for a whole frame
    input wire ppr_pkg::ppr_fmt_type i_fmt,
    // Pixel side
    input wire logic i_pix_valid,
    input wire logic [11:0] i_pix_data,
    input wire logic i_pix_first,
    input wire logic i_pix_last,
    output logic o_pix_ready,
    // Byte side
    output logic o_byte_valid,
    output logic [7:0] o_byte_data,
    output logic o_byte_first,
    output logic o_byte_last
);
    import ppr_pkg::*;

    logic [23:0] buf_ff;
    logic [2:0] first_ff;
    logic [2:0] last_ff;
    logic [1:0] cnt_ff;
    logic half_ff;
    logic [11:0] held_ff;
    logic held_first_ff;
    logic ready_ff;
    logic vld_ff, bfirst_ff, blast_ff;
    logic [7:0] bdata_ff;

    wire take = i_pix_valid & ready_ff;
    wire emit = (cnt_ff != 2'h0);
    wire is_pk = (i_fmt == PPR_FMT_TWELVE_BIT_TWO_PIXEL_PACKING);
    // Pair A is the held pixel; an odd last pixel pairs with zero
    wire [11:0] pa = half_ff ? held_ff : i_pix_data;
    wire [11:0] pb = half_ff ? i_pix_data : 12'h000;
    wire pa_first = half_ff ? held_first_ff : i_pix_first;

    logic load;
    logic [1:0] ld_n;
    logic [23:0] ld_data;
    logic [2:0] ld_first, ld_last;

    always_comb
    begin
        load = 1'b0;
        ld_n = 2'h0;
        ld_data = 24'h00_0000;
        ld_first = 3'h0;
        ld_last = 3'h0;
        unique case (i_fmt)
            PPR_FMT_MONO12:
            begin
                // High byte carries four zero bits above the pixel
                load = take;
                ld_n = 2'h2;
                ld_data = {8'h00, 4'h0, i_pix_data};
                ld_first = {2'h0, i_pix_first};
                ld_last = {1'b0, i_pix_last, 1'b0};
            end
            PPR_FMT_TWELVE_BIT_TWO_PIXEL_PACKING:
            begin
                // Bytes: A[11:4], {B[3:0],A[3:0]}, B[11:4]
                load = take & (half_ff | i_pix_last);
                ld_n = 2'h3;
                ld_data = {pb[11:4], pb[3:0], pa[3:0], pa[11:4]};
                ld_first = {2'h0, pa_first};
                ld_last = {i_pix_last, 2'h0};
            end
            default:
            begin
                // Upper bits of the sensor sample form the 8-bit word
                load = take;
                ld_n = 2'h1;
                ld_data = {16'h0000, i_pix_data[11:4]};
                ld_first = {2'h0, i_pix_first};
                ld_last = {2'h0, i_pix_last};
            end
        endcase
    end

    // Accept only when the buffer empties this cycle, so a load never
    // overwrites pending bytes and every group ends on a byte
    wire [1:0] nxt_cnt = load ? ld_n : cnt_ff - {1'b0, emit};
    wire nxt_half = is_pk & take ? ~half_ff & ~i_pix_last : half_ff;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            buf_ff <= 24'h00_0000;
            first_ff <= 3'h0;
            last_ff <= 3'h0;
            cnt_ff <= 2'h0;
            half_ff <= 1'b0;
            held_ff <= 12'h000;
            held_first_ff <= 1'b0;
            ready_ff <= 1'b1;
            vld_ff <= 1'b0;
            bdata_ff <= 8'h00;
            bfirst_ff <= 1'b0;
            blast_ff <= 1'b0;
        end
        else
        begin
            if (load)
            begin
                buf_ff <= ld_data;
                first_ff <= ld_first;
                last_ff <= ld_last;
            end
            else if (emit)
            begin
                buf_ff <= {8'h00, buf_ff[23:8]};
                first_ff <= {1'b0, first_ff[2:1]};
                last_ff <= {1'b0, last_ff[2:1]};
            end
            if (take & ~half_ff)
            begin
                held_ff <= i_pix_data;
                held_first_ff <= i_pix_first;
            end
            cnt_ff <= nxt_cnt;
            half_ff <= nxt_half;
            ready_ff <= (nxt_cnt <= 2'h1);
            vld_ff <= emit;
            bdata_ff <= buf_ff[7:0];
            bfirst_ff <= emit & first_ff[0];
            blast_ff <= emit & last_ff[0];
        end
    end

    assign o_pix_ready = ready_ff;
    assign o_byte_valid = vld_ff;
    assign o_byte_data = bdata_ff;
    assign o_byte_first = bfirst_ff;
    assign o_byte_last = blast_ff;
endmodule
`default_nettype wire

//--- hw/ppr_pixel_out.sv
// Pixel output stage: formatting, window crop and frame overlap
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ppr_consts.svh"
module ppr_pixel_out
#(
    parameter int SENSOR_BITS = 12,
    parameter logic [15:0] SENSOR_W = 16'h0800,
    parameter logic [15:0] SENSOR_H = 16'h0800
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // APB slave
    input wire logic [11:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Sensor readout control
    input wire logic i_frame_start,
    output logic o_capture_allow,
    output logic [15:0] o_row_first,
    output logic [15:0] o_row_count,
    // Sensor pixel stream, full lines of window rows
    input wire logic i_pix_valid,
    input wire logic [11:0] i_pix_data,
    input wire logic i_pix_sof,
    input wire logic i_pix_sol,
    output logic o_pix_ready,
    // Host link byte stream
    output logic o_byte_valid,
    output logic [7:0] o_byte_data,
    output logic o_byte_sof,
    output logic o_byte_eof,
    output logic o_out_busy
);
    import ppr_pkg::*;

    // ==========================================================
    // Helpers

    // Steps are powers of two, so rounding down is a mask
    function automatic logic [15:0] round_dn(input logic [15:0] v,
                                             input logic [15:0] step);
        return v & ~(step - 16'h0001);
    endfunction

    function automatic logic [15:0] at_least(input logic [15:0] v,
                                             input logic [15:0] lo);
        return (v < lo) ? lo : v;
    endfunction

    function automatic logic [15:0] at_most(input logic [15:0] v,
                                            input logic [15:0] hi);
        return (v > hi) ? hi : v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Software registers

    logic [31:0] ctrl_ff;
    logic [31:0] win_x_ff;
    logic [31:0] win_y_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    wire setup = i_psel & ~i_penable;
    wire wr_en = i_psel & i_penable & pready_ff & i_pwrite;
    wire hit_ctrl = (i_paddr == `PPR_OFS_CTRL);
    wire hit_wx = (i_paddr == `PPR_OFS_WIN_X);
    wire hit_wy = (i_paddr == `PPR_OFS_WIN_Y);
    wire hit_st = (i_paddr == `PPR_OFS_STATUS);
    wire hit_ex = (i_paddr == `PPR_OFS_EFF_X);
    wire hit_ey = (i_paddr == `PPR_OFS_EFF_Y);
    wire hit_any = hit_ctrl | hit_wx | hit_wy | hit_st | hit_ex | hit_ey;

    // ==========================================================
    // Format and window legalization

    wire [1:0] fmt_req = ctrl_ff[`PPR_CTRL_FMT_LSB +: 2];
    wire [1:0] fam_req = ctrl_ff[`PPR_CTRL_FAM_LSB +: 2];
    wire deep_ok = (SENSOR_BITS >= 12);
    // Deep formats only when the sensor delivers twelve bits
    wire fmt_fallback = (fmt_req != 2'h0) & (~deep_ok | fmt_req == 2'h3);
    wire ppr_fmt_type eff_fmt = fmt_fallback ? PPR_FMT_MONO8
                                             : ppr_fmt_type'(fmt_req);
    wire is12 = (eff_fmt != PPR_FMT_MONO8);
    wire is_ccd = (fam_req == 2'(PPR_FAM_INTERLINE_CCD));
    wire is_cmos = (fam_req == 2'(PPR_FAM_CMOS_4MP));

    // Width step is shared by all families
    wire [15:0] w_step = is12 ? `PPR_W_STEP_12 : `PPR_W_STEP_8;
    // Only the CCD coarsens the x offset at twelve bits
    wire [15:0] x_step = (is_ccd & is12) ? `PPR_X_STEP_CCD_12
                                         : `PPR_X_STEP_8;
    wire [15:0] h_step = is_ccd ? `PPR_H_STEP_CCD : `PPR_H_STEP;
    wire [15:0] min_w = is_ccd ? `PPR_MIN_CCD
                      : is_cmos ? `PPR_MIN_CMOS : `PPR_MIN_W_FIRST;
    wire [15:0] min_h = is_ccd ? `PPR_MIN_CCD
                      : is_cmos ? `PPR_MIN_CMOS : `PPR_MIN_H_FIRST;

    wire [15:0] req_w = win_x_ff[15:0];
    wire [15:0] req_xo = win_x_ff[31:16];
    wire [15:0] req_h = win_y_ff[15:0];
    wire [15:0] req_yo = win_y_ff[31:16];

    // Oversized values are clamped, off-step values rounded down
    wire [15:0] leg_w = at_least(round_dn(at_most(req_w, SENSOR_W),
                                          w_step), min_w);
    wire [15:0] leg_h = at_least(round_dn(at_most(req_h, SENSOR_H),
                                          h_step), min_h);
    wire [15:0] leg_xo = round_dn(at_most(req_xo, SENSOR_W - leg_w),
                                  x_step);
    wire [15:0] leg_yo = round_dn(at_most(req_yo, SENSOR_H - leg_h),
                                  `PPR_Y_STEP);
    wire adjusted = (leg_w != req_w) | (leg_h != req_h)
                  | (leg_xo != req_xo) | (leg_yo != req_yo);

    // ==========================================================
    // Capture-side and output-side configuration sets

    // Capture set is taken at exposure start, output set at the first
    // pixel, so a new frame can start while the last one still drains
    ppr_fmt_type cap_fmt_ff, out_fmt_ff;
    logic [15:0] cap_w_ff, cap_xo_ff, cap_h_ff, cap_yo_ff;
    logic [15:0] out_w_ff, out_xo_ff, out_h_ff;
    logic cap_allow_ff;
    logic [15:0] row_first_ff, row_count_ff;
    logic [15:0] cap_frames_ff, out_frames_ff;
    logic busy_ff;

    // ==========================================================
    // Pixel column and row tracking

    logic [15:0] x_ff, y_ff;
    logic first_pend_ff;
    logic pk_ready, pk_bvalid, pk_bfirst, pk_blast;
    logic [7:0] pk_bdata;

    wire accept = i_pix_valid & pk_ready;
    wire new_frame = accept & i_pix_sof;
    wire [15:0] cur_w = i_pix_sof ? cap_w_ff : out_w_ff;
    wire [15:0] cur_xo = i_pix_sof ? cap_xo_ff : out_xo_ff;
    wire [15:0] cur_h = i_pix_sof ? cap_h_ff : out_h_ff;
    wire ppr_fmt_type cur_fmt = i_pix_sof ? cap_fmt_ff : out_fmt_ff;
    wire [15:0] cur_x = (i_pix_sol | i_pix_sof) ? 16'h0000 : x_ff;
    wire [15:0] cur_y = i_pix_sof ? 16'h0000
                      : i_pix_sol ? y_ff + 16'h0001 : y_ff;
    wire [15:0] x_end = cur_xo + cur_w;
    // Lines arrive whole; columns outside the window are dropped
    wire in_col = (cur_x >= cur_xo) & (cur_x < x_end);
    // Rows beyond the window height are dropped as a guard
    wire in_row = (cur_y < cur_h);
    wire keep = in_col & in_row;
    wire last_pix = keep & (cur_x == x_end - 16'h0001)
                  & (cur_y == cur_h - 16'h0001);
    wire pk_first = i_pix_sof | first_pend_ff;
    wire frame_done = pk_bvalid & pk_blast;

    // ==========================================================
    // APB slave: zero wait states, error on unmapped offsets

    wire [31:0] status = {out_frames_ff, cap_frames_ff[11:0],
                          busy_ff, cap_allow_ff, fmt_fallback, adjusted};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_ff
                       : hit_wx ? win_x_ff
                       : hit_wy ? win_y_ff
                       : hit_st ? status
                       : hit_ex ? {leg_xo, leg_w}
                       : hit_ey ? {leg_yo, leg_h}
                       : 32'h0000_0000;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            pready_ff <= setup;
            pslverr_ff <= setup & ~hit_any;
            prdata_ff <= (setup & ~i_pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            ctrl_ff <= `PPR_RST_CTRL;
            win_x_ff <= {16'h0000, SENSOR_W};
            win_y_ff <= {16'h0000, SENSOR_H};
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
            begin
                ctrl_ff <= merge(ctrl_ff, i_pwdata, i_pstrb);
            end
            if (hit_wx)
            begin
                win_x_ff <= merge(win_x_ff, i_pwdata, i_pstrb);
            end
            if (hit_wy)
            begin
                win_y_ff <= merge(win_y_ff, i_pwdata, i_pstrb);
            end
        end
    end

    // ==========================================================
    // Capture set and sensor row window

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            cap_fmt_ff <= PPR_FMT_MONO8;
            cap_w_ff <= SENSOR_W;
            cap_xo_ff <= 16'h0000;
            cap_h_ff <= SENSOR_H;
            cap_yo_ff <= 16'h0000;
            cap_allow_ff <= 1'b0;
            row_first_ff <= 16'h0000;
            row_count_ff <= SENSOR_H;
            cap_frames_ff <= 16'h0000;
        end
        else
        begin
            // Capture is never held off by a frame still in output
            cap_allow_ff <= ctrl_ff[`PPR_CTRL_EN];
            if (i_frame_start)
            begin
                cap_fmt_ff <= eff_fmt;
                cap_w_ff <= leg_w;
                cap_xo_ff <= leg_xo;
                cap_h_ff <= leg_h;
                cap_yo_ff <= leg_yo;
                // Sensor reads only the window rows
                row_first_ff <= leg_yo;
                row_count_ff <= leg_h;
                cap_frames_ff <= cap_frames_ff + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Output set, counters and busy flag

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            out_fmt_ff <= PPR_FMT_MONO8;
            out_w_ff <= SENSOR_W;
            out_xo_ff <= 16'h0000;
            out_h_ff <= SENSOR_H;
            x_ff <= 16'h0000;
            y_ff <= 16'h0000;
            first_pend_ff <= 1'b0;
            busy_ff <= 1'b0;
            out_frames_ff <= 16'h0000;
        end
        else
        begin
            if (new_frame)
            begin
                out_fmt_ff <= cap_fmt_ff;
                out_w_ff <= cap_w_ff;
                out_xo_ff <= cap_xo_ff;
                out_h_ff <= cap_h_ff;
            end
            if (accept)
            begin
                x_ff <= cur_x + 16'h0001;
                y_ff <= cur_y;
                first_pend_ff <= pk_first & ~keep;
            end
            // Busy ends on the last byte, not on exposure end
            busy_ff <= new_frame | (busy_ff & ~frame_done);
            if (frame_done)
            begin
                out_frames_ff <= out_frames_ff + 16'h0001;
            end
        end
    end

    // ==========================================================
    // Byte packing

    // In the twelve-bit formats samples pass whole, so all 4096 codes reach the host; 8-bit keeps bits 11:4
    ppr_byte_packer u_packer
    (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_fmt(cur_fmt),
        .i_pix_valid(i_pix_valid & keep),
        .i_pix_data(i_pix_data),
        .i_pix_first(pk_first),
        .i_pix_last(last_pix),
        .o_pix_ready(pk_ready),
        .o_byte_valid(pk_bvalid),
        .o_byte_data(pk_bdata),
        .o_byte_first(pk_bfirst),
        .o_byte_last(pk_blast)
    );

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_capture_allow = cap_allow_ff;
    assign o_row_first = row_first_ff;
    assign o_row_count = row_count_ff;
    assign o_pix_ready = pk_ready;
    assign o_byte_valid = pk_bvalid;
    assign o_byte_data = pk_bdata;
    assign o_byte_sof = pk_bfirst;
    assign o_byte_eof = pk_blast;
    assign o_out_busy = busy_ff;
endmodule
`default_nettype wire

//--- pkg/ppr_consts.svh
// Register offsets, field positions, reset values and window steps
`ifndef PPR_CONSTS_SVH
`define PPR_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define PPR_OFS_CTRL 12'h000
`define PPR_OFS_WIN_X 12'h004
`define PPR_OFS_WIN_Y 12'h008
`define PPR_OFS_STATUS 12'h00C
`define PPR_OFS_EFF_X 12'h010
`define PPR_OFS_EFF_Y 12'h014

// ==========================================================
// Control fields
`define PPR_CTRL_EN 0
`define PPR_CTRL_FMT_LSB 1
`define PPR_CTRL_FAM_LSB 3
`define PPR_RST_CTRL 32'h0000_0000

// ==========================================================
// Window granularity per bit depth and sensor family
`define PPR_W_STEP_8 16'h0008
`define PPR_W_STEP_12 16'h0010
`define PPR_X_STEP_8 16'h0008
`define PPR_X_STEP_CCD_12 16'h0010
`define PPR_H_STEP 16'h0002
`define PPR_H_STEP_CCD 16'h0001
`define PPR_Y_STEP 16'h0002
`define PPR_MIN_W_FIRST 16'h0080
`define PPR_MIN_H_FIRST 16'h0002
`define PPR_MIN_CCD 16'h0010
`define PPR_MIN_CMOS 16'h0020

`endif

//--- pkg/ppr_pkg.sv
// Types shared by the pixel output stage
`default_nettype none
package ppr_pkg;
    // Code 3 is illegal and falls back to 8-bit output
    typedef enum logic [1:0] {
        PPR_FMT_MONO8,
        PPR_FMT_MONO12,
        PPR_FMT_TWELVE_BIT_TWO_PIXEL_PACKING
    } ppr_fmt_type;

    // Code 3 is illegal and is treated as the first family
    typedef enum logic [1:0] {
        PPR_FAM_FIRST,
        PPR_FAM_INTERLINE_CCD,
        PPR_FAM_CMOS_4MP
    } ppr_fam_type;
endpackage
`default_nettype wire

//--- verification/ppr_host_model.sv
// Host side model that takes every byte of the link stream
`timescale 1ns/1ps
`default_nettype none
module ppr_host_model
(
    // Clock
    input wire logic i_mclk,
    // Byte stream
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    input wire logic i_sof,
    input wire logic i_eof
);
    // Entries are {sof, eof, data}; the bench empties it per frame
    logic [9:0] q[$];

    // No back-pressure exists, so a missed byte would be lost for good
    always @(posedge i_mclk)
    begin
        if (i_valid === 1'b1)
            q.push_back({i_sof, i_eof, i_data});
    end
endmodule
`default_nettype wire

//--- verification/ppr_pixel_out_bench.sv
// Self-checking bench for the pixel output stage
`timescale 1ns/1ps
`default_nettype none
module ppr_pixel_out_bench;
    localparam int XO = 16;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [31:0] pwd = 32'h0;
    logic fs = 1'b0;
    logic pv = 1'b0;
    logic [11:0] pd = 12'h000;
    logic psof = 1'b0;
    logic psol = 1'b0;
    wire logic [31:0] prd;
    wire logic prdy, perr, cap, prdy_pix, bv, bsof, beof, busy;
    wire logic [15:0] rfirst, rcount;
    wire logic [7:0] bd;
    int num_errors = 0;
    int n_compared = 0;
    logic [31:0] rd;
    logic er;
    // Control, window and legal window per case
    logic [31:0] tc [4] = '{32'h1, 32'h5, 32'h0B, 32'h13};
    logic [31:0] tx [4] = '{32'h000D_00C8, 32'h000D_00C8, 32'h0014_0028, 32'h000D_0014};
    logic [31:0] ex [4] = '{32'h0008_00C8, 32'h0008_00C0, 32'h0010_0020, 32'h0008_0020};
    logic [31:0] ty [4] = '{32'h0005_0003, 32'h0005_0003, 32'h0003_0011, 32'h0003_0021};
    logic [31:0] ey [4] = '{32'h0004_0002, 32'h0004_0002, 32'h0002_0011, 32'h0002_0020};

    always #12.5 mclk = ~mclk;

    ppr_pixel_out #(.SENSOR_BITS(12), .SENSOR_W(16'h0100), .SENSOR_H(16'h0040)) i_ppr_pixel_out
    (
        .i_mclk(mclk), .i_rst(rst), .i_paddr(paddr), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_pwdata(pwd), .i_pstrb(4'hF),
        .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
        .i_frame_start(fs), .o_capture_allow(cap), .o_row_first(rfirst),
        .o_row_count(rcount), .i_pix_valid(pv), .i_pix_data(pd),
        .i_pix_sof(psof), .i_pix_sol(psol), .o_pix_ready(prdy_pix),
        .o_byte_valid(bv), .o_byte_data(bd), .o_byte_sof(bsof),
        .o_byte_eof(beof), .o_out_busy(busy)
    );
    ppr_host_model i_ppr_host_model
    (
        .i_mclk(mclk), .i_valid(bv), .i_data(bd), .i_sof(bsof), .i_eof(beof)
    );

    // Pattern reaches both 12'h000 and 12'hFFF inside the window
    function automatic logic [11:0] pix(input int r, input int c);
        pix = {c[3:0], c[3:0], r[3:0]};
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge mclk);
        pen <= 1'b1;
        @(posedge mclk);
        // Request stands until the edge that samples pready high
        while (prdy !== 1'b1)
            @(posedge mclk);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Sensor sends full lines of the window rows, the block crops columns
    task frame(input int f);
        logic [11:0] px[$];
        logic [7:0] eb[$];
        int n;
        px = {};
        eb = {};
        i_ppr_host_model.q = {};
        fs <= 1'b1;
        @(posedge mclk);
        fs <= 1'b0;
        @(negedge mclk);
        chk({16'h0, rfirst}, 32'd2);
        chk({16'h0, rcount}, 32'd16);
        for (int r = 0; r < 16; r++)
            for (int c = 0; c < 256; c++)
            begin
                @(posedge mclk);
                if (r == 1 && c == 0)
                begin
                    pv <= 1'b0;
                    fs <= 1'b1;
                    @(posedge mclk);
                    fs <= 1'b0;
                end
                pv <= 1'b1;
                pd <= pix(r + 2, c);
                psof <= (r == 0 && c == 0);
                psol <= (c == 0);
                if (c >= XO && c < XO + 16)
                    px.push_back(pix(r + 2, c));
                @(negedge mclk);
                if (r == 1 && c == 0)
                begin
                    chk({31'h0, cap}, 32'h1);
                    chk({31'h0, busy}, 32'h1);
                end
                if (r == 15 && c == XO + 16)
                    chk({31'h0, busy}, 32'h1);
                while (prdy_pix !== 1'b1)
                    @(negedge mclk);
            end
        @(posedge mclk);
        pv <= 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        chk({31'h0, busy}, 32'h0);
        case (f)
            0: foreach (px[i]) eb.push_back(px[i][11:4]);
            1: foreach (px[i])
            begin
                eb.push_back(px[i][7:0]);
                eb.push_back({4'h0, px[i][11:8]});
            end
            default: for (int i = 0; i < px.size(); i += 2)
            begin
                eb.push_back(px[i][11:4]);
                eb.push_back({px[i + 1][3:0], px[i][3:0]});
                eb.push_back(px[i + 1][11:4]);
            end
        endcase
        chk(i_ppr_host_model.q.size(), eb.size());
        foreach (eb[i])
            chk({22'h0, i_ppr_host_model.q[i]}, {22'h0, i == 0, i == eb.size() - 1, eb[i]});
    endtask

    task wrap_up;
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rchk(12'h000, 32'h0);
        rchk(12'h004, 32'h0000_0100);
        rchk(12'h008, 32'h0000_0040);
        rchk(12'h018, 32'h0);
        chk({31'h0, er}, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 12'h000, tc[i]);
            apb(1'b1, 12'h004, tx[i]);
            apb(1'b1, 12'h008, ty[i]);
            rchk(12'h010, ex[i]);
            rchk(12'h014, ey[i]);
        end
        // Illegal format code falls back to 8-bit, first family minimum
        apb(1'b1, 12'h000, 32'h7);
        rchk(12'h00C, 32'h0000_0007);
        rchk(12'h010, 32'h0008_0080);
        apb(1'b1, 12'h004, 32'h0010_0010);
        apb(1'b1, 12'h008, 32'h0002_0010);
        for (int f = 0; f < 3; f++)
        begin
            apb(1'b1, 12'h000, 32'h9 | (f << 1));
            frame(f);
        end
        wrap_up;
    end

    // Three frames need about 13000 cycles
    initial
    begin
        #(25 * 80000);
        num_errors++;
        wrap_up;
    end
endmodule
`default_nettype wire

//--- verification/ppr_pixel_out_checker.sv
// Port checks for the pixel output stage
`timescale 1ns/1ps
`default_nettype none
module ppr_pixel_out_checker
#(
    parameter logic [15:0] SENSOR_H = 16'h0800
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // APB
    input wire logic [11:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Streams
    input wire logic i_frame_start,
    input wire logic [15:0] o_row_count,
    input wire logic o_pix_ready,
    input wire logic o_byte_valid,
    input wire logic o_byte_sof,
    input wire logic o_byte_eof
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    // ==========================================================
    // Bus phases
    sequence setup_s;
        i_psel && !i_penable;
    endsequence
    sequence access_s;
        o_pready && i_psel && i_penable;
    endsequence

    // ==========================================================
    // Assertions
    setup_ready_a: assert property (setup_s |=> access_s)
        else $error("pready missing after setup");
    pready_pulse_a: assert property (access_s |=> !o_pready)
        else $error("pready longer than one cycle");
    unmapped_err_a: assert property (o_pready && i_paddr > 12'h014 |-> o_pslverr)
        else $error("no error on unmapped offset");
    mapped_ok_a: assert property (o_pready && i_paddr <= 12'h014 && i_paddr[1:0] == 2'b00 |-> !o_pslverr)
        else $error("error on mapped offset");
    idle_rdata_a: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside access");
    sof_valid_a: assert property (o_byte_sof |-> o_byte_valid)
        else $error("frame start without byte");
    eof_valid_a: assert property (o_byte_eof |-> o_byte_valid)
        else $error("frame end without byte");
    row_hold_a: assert property ($changed(o_row_count) |-> $past(i_frame_start) || $past(i_rst))
        else $error("row count moved without frame start");
    // Checked through reset itself, so the default disable is lifted
    reset_state_a: assert property (disable iff (1'b0) i_rst |=> o_pix_ready && !o_byte_valid && o_row_count == SENSOR_H)
        else $error("wrong state after reset");
endmodule

bind ppr_pixel_out ppr_pixel_out_checker #(.SENSOR_H(SENSOR_H)) i_ppr_pixel_out_checker
(
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_paddr(i_paddr),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_frame_start(i_frame_start),
    .o_row_count(o_row_count),
    .o_pix_ready(o_pix_ready),
    .o_byte_valid(o_byte_valid),
    .o_byte_sof(o_byte_sof),
    .o_byte_eof(o_byte_eof)
);
`default_nettype wire
